/* File: logic/nvsc_pkg.sv */
// Shared constants, types and helpers of the nonvolatile SRAM host sequencer
package nvsc_pkg;

  // ----------------------------------------------------------------
  // Bus widths and clock
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W        = 13;
  localparam int unsigned DATA_W        = 8;
  localparam int unsigned CLK_PERIOD_NS = 10;

  // ----------------------------------------------------------------
  // Timing, each in its own unit, then as clock counts
  // ----------------------------------------------------------------
  localparam int unsigned T_ACCESS_NS   = 55;   // Slowest cycle time, least
  localparam int unsigned T_STORE_MS    = 10;   // Store duration, longest
  localparam int unsigned T_RECALL_US   = 20;   // Recall duration, longest
  localparam int unsigned T_ASSERT_NS   = 250;  // Hardware store pulse, least
  localparam int unsigned T_RECOVER_NS  = 300;  // Release to access, longest

  localparam int unsigned ACC_CYC     = (T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned STORE_CYC   = (T_STORE_MS * 1000000) / CLK_PERIOD_NS;
  localparam int unsigned RECALL_CYC  = (T_RECALL_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned ASSERT_CYC  = (T_ASSERT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RECOVER_CYC = (T_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Initiation sequence
  // ----------------------------------------------------------------
  localparam logic [2:0]        SEQ_LAST    = 3'h5;
  localparam logic [ADDR_W-1:0] SEQ_A0      = 13'h0000;
  localparam logic [ADDR_W-1:0] SEQ_A1      = 13'h1555;
  localparam logic [ADDR_W-1:0] SEQ_A2      = 13'h0aaa;
  localparam logic [ADDR_W-1:0] SEQ_A3      = 13'h1fff;
  localparam logic [ADDR_W-1:0] SEQ_A4      = 13'h10f0;
  localparam logic [ADDR_W-1:0] STORE_LAST  = 13'h0f0f;
  localparam logic [ADDR_W-1:0] RECALL_LAST = 13'h0f0e;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_READ,
    OP_WRITE,
    OP_STORE,
    OP_RECALL,
    OP_HW_STORE
  } nvsc_op_t;

  typedef struct packed {
    nvsc_op_t          op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } nvsc_cmd_t;

  typedef struct packed {
    logic              ce_n;
    logic              we_n;
    logic              oe_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq;
    logic              dq_oe;
  } nvsc_pins_t;

  localparam nvsc_pins_t PINS_IDLE = '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1,
                                       addr: '0, dq: '0, dq_oe: 1'b0};

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ACCESS,
    ST_SEQ,
    ST_NV_WAIT,
    ST_HW_PULSE,
    ST_HW_WAIT,
    ST_RECOVER
  } nvsc_state_t;

  // Address of a given step of the initiation sequence
  function automatic logic [ADDR_W-1:0] seq_addr(input logic [2:0] step,
                                                 input logic       recall);
    logic [ADDR_W-1:0] a;
    a = SEQ_A0;
    unique case (step)
      3'h0: a = SEQ_A0;
      3'h1: a = SEQ_A1;
      3'h2: a = SEQ_A2;
      3'h3: a = SEQ_A3;
      3'h4: a = SEQ_A4;
      default: a = recall ? RECALL_LAST : STORE_LAST;
    endcase
    return a;
  endfunction

endpackage

/* File: logic/nvsc_access.sv */
// One asynchronous SRAM read or write access, timed in clock cycles
`timescale 1ns/1ps
module nvsc_access #(
  parameter int unsigned ACC_CYC = nvsc_pkg::ACC_CYC
) (
  input  wire logic                         sys_clk_i, // System clock
  input  wire logic                         reset_i,   // Synchronous reset
  input  wire logic                         start_i,   // Launch one access
  input  wire logic                         write_i,   // Access is a write
  input  wire logic                         oe_en_i,   // Read drives output enable
  input  wire logic [nvsc_pkg::ADDR_W-1:0]  addr_i,    // Access address
  input  wire logic [nvsc_pkg::DATA_W-1:0]  wdata_i,   // Write data
  input  wire logic [nvsc_pkg::DATA_W-1:0]  dq_i,      // Data pins in
  output nvsc_pkg::nvsc_pins_t              pins_o,    // Memory pins out
  output logic [nvsc_pkg::DATA_W-1:0]       rdata_o,   // Captured read data
  output logic                              done_o     // Access finished
);

  if (ACC_CYC < 1 || ACC_CYC > 15)
  begin : g_bad_acc_cyc
    $error("ACC_CYC out of range");
  end

  logic       active_reg;
  logic       write_reg;
  logic       oe_en_reg;
  logic [3:0] cnt_reg;
  wire        last_w = active_reg && (cnt_reg == 4'(ACC_CYC));

  // ----------------------------------------------------------------
  // Phase counter: one setup cycle, then ACC_CYC cycles enabled
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      active_reg <= 1'b0;
      cnt_reg    <= 4'h0;
      write_reg  <= 1'b0;
      oe_en_reg  <= 1'b0;
    end
    else if (start_i && !active_reg)
    begin
      active_reg <= 1'b1;
      cnt_reg    <= 4'h0;
      write_reg  <= write_i;
      oe_en_reg  <= oe_en_i;
    end
    else if (last_w)
      active_reg <= 1'b0;
    else if (active_reg)
      cnt_reg <= cnt_reg + 4'h1;
  end

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
      pins_o <= nvsc_pkg::PINS_IDLE;
    else if (start_i && !active_reg)
    begin
      pins_o.addr <= addr_i;
      pins_o.dq   <= wdata_i;
    end
    else if (active_reg && cnt_reg == 4'h0)
    begin
      pins_o.ce_n  <= 1'b0;
      pins_o.we_n  <= !write_reg; // RL9
      pins_o.oe_n  <= write_reg || !oe_en_reg;
      pins_o.dq_oe <= write_reg;
    end
    else if (last_w)
    begin
      pins_o.ce_n  <= 1'b1;
      pins_o.we_n  <= 1'b1;
      pins_o.oe_n  <= 1'b1;
      pins_o.dq_oe <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      rdata_o <= '0;
      done_o  <= 1'b0;
    end
    else
    begin
      done_o <= last_w;
      if (last_w && !write_reg)
        rdata_o <= dq_i;
    end
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);

  read_we_high_a: assert property ( // RL9
    (!pins_o.ce_n && !write_reg) |-> pins_o.we_n)
    else $error("write enable low during a read");

  write_drive_a: assert property (
    $fell(pins_o.we_n) |-> pins_o.dq_oe && pins_o.oe_n && !pins_o.ce_n)
    else $error("write without data drive");

endmodule

/* File: logic/nvsc_host.sv */
// Host sequencer for an SRAM with nonvolatile shadow store and recall
// Notes on behaviour
// RL1 - Store needs six reads ending at 0F0F
// RL2 - Recall needs same reads ending at 0F0E
// RL3 - Write enable stays high during sequence
// RL4 - Device ignores output enable for launch
// RL5 - Pin store skipped without writes since store
// RL6 - After pin store, wait for pin high
// RL7 - Write enable low first keeps outputs off
// RL8 - Chip disable never cuts nonvolatile cycle
// RL9 - Write enable high throughout ordinary reads
// RL10 - Read when chip, output enable low
// RL11 - Write when chip, write enable low
// RL12 - Wrong address aborts the sequence
// RL13 - Device ignores all inputs during store
// RL14 - Sixth access leaves outputs off, launches
// RL15 - Address taken on chip enable fall
`timescale 1ns/1ps
module nvsc_host #(
  parameter int unsigned STORE_CYC  = nvsc_pkg::STORE_CYC,
  parameter int unsigned RECALL_CYC = nvsc_pkg::RECALL_CYC
) (
  input  wire logic                         sys_clk_i,   // System clock
  input  wire logic                         reset_i,     // Synchronous reset
  input  wire logic                         cmd_valid_i, // Command offered
  input  nvsc_pkg::nvsc_cmd_t               cmd_i,       // Command
  output logic                              cmd_ready_o, // Command taken
  output logic                              rsp_valid_o, // Read data valid
  output logic [nvsc_pkg::DATA_W-1:0]       rsp_data_o,  // Read data
  output logic                              busy_o,      // Operation running
  input  wire logic [nvsc_pkg::DATA_W-1:0]  dq_i,        // Data pins in
  output nvsc_pkg::nvsc_pins_t              pins_o,      // Memory pins out
  input  wire logic                         hsb_i,       // Store/busy pin level
  output logic                              hsb_o,       // Store/busy pin value
  output logic                              hsb_oe_o     // Store/busy pin drive
);

  if (STORE_CYC < 1 || STORE_CYC >= (1 << 24) || RECALL_CYC < 1
      || RECALL_CYC >= (1 << 24))
  begin : g_bad_nv_cyc
    $error("nonvolatile cycle counts out of range");
  end

  nvsc_pkg::nvsc_state_t             state_reg;
  nvsc_pkg::nvsc_op_t                op_reg;
  logic [2:0]                        step_reg;
  logic [23:0]                       cnt_reg;
  logic                              start_reg;
  logic                              acc_write_reg;
  logic                              acc_oe_en_reg;
  logic [nvsc_pkg::ADDR_W-1:0]       acc_addr_reg;
  logic [nvsc_pkg::DATA_W-1:0]       acc_data_reg;
  logic [nvsc_pkg::DATA_W-1:0]       rdata_w;
  logic                              done_w;
  wire                               recall_w = (op_reg == nvsc_pkg::OP_RECALL);
  wire  [23:0]                       nv_last_w = recall_w ? 24'(RECALL_CYC - 1)
                                                          : 24'(STORE_CYC - 1);

  // ----------------------------------------------------------------
  // Single access engine
  // ----------------------------------------------------------------
  nvsc_access u_access (
    .sys_clk_i (sys_clk_i),
    .reset_i   (reset_i),
    .start_i   (start_reg),
    .write_i   (acc_write_reg),
    .oe_en_i   (acc_oe_en_reg),
    .addr_i    (acc_addr_reg),
    .wdata_i   (acc_data_reg),
    .dq_i      (dq_i),
    .pins_o    (pins_o),
    .rdata_o   (rdata_w),
    .done_o    (done_w)
  );

  // ----------------------------------------------------------------
  // Operation sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      state_reg     <= nvsc_pkg::ST_IDLE;
      op_reg        <= nvsc_pkg::OP_READ;
      step_reg      <= 3'h0;
      cnt_reg       <= 24'h0;
      start_reg     <= 1'b0;
      acc_write_reg <= 1'b0;
      acc_oe_en_reg <= 1'b0;
      acc_addr_reg  <= '0;
      acc_data_reg  <= '0;
      cmd_ready_o   <= 1'b0;
      busy_o        <= 1'b0;
      hsb_oe_o      <= 1'b0;
    end
    else
    begin
      start_reg <= 1'b0;
      unique case (state_reg)
        nvsc_pkg::ST_IDLE:
        begin
          cmd_ready_o <= 1'b1;
          busy_o      <= 1'b0;
          if (cmd_valid_i && cmd_ready_o)
          begin
            cmd_ready_o   <= 1'b0;
            busy_o        <= 1'b1;
            op_reg        <= cmd_i.op;
            step_reg      <= 3'h0;
            cnt_reg       <= 24'h0;
            acc_write_reg <= (cmd_i.op == nvsc_pkg::OP_WRITE);
            acc_oe_en_reg <= 1'b1;
            acc_data_reg  <= cmd_i.data;
            unique case (cmd_i.op)
              nvsc_pkg::OP_READ, nvsc_pkg::OP_WRITE:
              begin
                acc_addr_reg <= cmd_i.addr;
                start_reg    <= 1'b1;
                state_reg    <= nvsc_pkg::ST_ACCESS;
              end
              nvsc_pkg::OP_STORE, nvsc_pkg::OP_RECALL:
              begin
                acc_addr_reg <= nvsc_pkg::SEQ_A0; // RL1
                start_reg    <= 1'b1;
                state_reg    <= nvsc_pkg::ST_SEQ;
              end
              nvsc_pkg::OP_HW_STORE:
              begin
                hsb_oe_o  <= 1'b1;
                state_reg <= nvsc_pkg::ST_HW_PULSE;
              end
              default:
              begin
                cmd_ready_o <= 1'b1;
                busy_o      <= 1'b0;
              end
            endcase
          end
        end
        nvsc_pkg::ST_ACCESS:
          if (done_w)
            state_reg <= nvsc_pkg::ST_IDLE;
        nvsc_pkg::ST_SEQ:
          if (done_w)
          begin
            if (step_reg == nvsc_pkg::SEQ_LAST)
            begin
              cnt_reg   <= 24'h0;
              state_reg <= nvsc_pkg::ST_NV_WAIT;
            end
            else
            begin
              step_reg      <= step_reg + 3'h1;
              acc_addr_reg  <= nvsc_pkg::seq_addr(step_reg + 3'h1, recall_w); // RL2
              acc_write_reg <= 1'b0; // RL3
              acc_oe_en_reg <= (step_reg + 3'h1 != nvsc_pkg::SEQ_LAST); // RL14
              start_reg     <= 1'b1;
            end
          end
        nvsc_pkg::ST_NV_WAIT:
        begin
          cnt_reg <= cnt_reg + 24'h1; // RL8
          if (cnt_reg == nv_last_w)
            state_reg <= nvsc_pkg::ST_IDLE;
        end
        nvsc_pkg::ST_HW_PULSE:
        begin
          cnt_reg <= cnt_reg + 24'h1;
          if (cnt_reg == 24'(nvsc_pkg::ASSERT_CYC - 1))
          begin
            hsb_oe_o  <= 1'b0;
            cnt_reg   <= 24'h0;
            state_reg <= nvsc_pkg::ST_HW_WAIT;
          end
        end
        nvsc_pkg::ST_HW_WAIT:
          if (hsb_i) // RL6
            state_reg <= nvsc_pkg::ST_RECOVER;
        nvsc_pkg::ST_RECOVER:
        begin
          cnt_reg <= cnt_reg + 24'h1;
          if (!hsb_i)
            cnt_reg <= 24'h0;
          else if (cnt_reg == 24'(nvsc_pkg::RECOVER_CYC - 1))
            state_reg <= nvsc_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Read response and store pin value
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      rsp_valid_o <= 1'b0;
      rsp_data_o  <= '0;
      hsb_o       <= 1'b0;
    end
    else
    begin
      rsp_valid_o <= done_w && state_reg == nvsc_pkg::ST_ACCESS && !acc_write_reg;
      if (done_w && state_reg == nvsc_pkg::ST_ACCESS && !acc_write_reg)
        rsp_data_o <= rdata_w;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);

  sequence seq_ce_fall;
    $fell(pins_o.ce_n) && state_reg == nvsc_pkg::ST_SEQ;
  endsequence

  sequence sixth_done;
    state_reg == nvsc_pkg::ST_SEQ && step_reg == nvsc_pkg::SEQ_LAST && done_w;
  endsequence

  seq_we_high_a: assert property ( // RL3
    state_reg == nvsc_pkg::ST_SEQ |-> pins_o.we_n)
    else $error("write enable low inside initiation sequence");

  seq_step_addr_a: assert property ( // RL1
    (seq_ce_fall and (step_reg < nvsc_pkg::SEQ_LAST)) |->
      pins_o.addr == nvsc_pkg::seq_addr(step_reg, 1'b0))
    else $error("wrong sequence address");

  store_last_addr_a: assert property ( // RL1
    (seq_ce_fall and (step_reg == nvsc_pkg::SEQ_LAST && op_reg == nvsc_pkg::OP_STORE))
      |-> pins_o.addr == nvsc_pkg::STORE_LAST)
    else $error("store sequence ends at wrong address");

  recall_last_addr_a: assert property ( // RL2
    (seq_ce_fall and (step_reg == nvsc_pkg::SEQ_LAST && op_reg == nvsc_pkg::OP_RECALL))
      |-> pins_o.addr == nvsc_pkg::RECALL_LAST)
    else $error("recall sequence ends at wrong address");

  sixth_oe_off_a: assert property ( // RL14
    (seq_ce_fall and (step_reg == nvsc_pkg::SEQ_LAST)) |-> pins_o.oe_n)
    else $error("output enable driven on launching access");

  nv_launch_a: assert property ( // RL1
    sixth_done |=> (state_reg == nvsc_pkg::ST_NV_WAIT && pins_o.ce_n) [*8])
    else $error("nonvolatile wait not entered");

  nv_wait_quiet_a: assert property ( // RL13
    state_reg == nvsc_pkg::ST_NV_WAIT |-> pins_o.ce_n && pins_o.we_n && !start_reg)
    else $error("access during nonvolatile cycle");

  hw_store_quiet_a: assert property ( // RL6
    state_reg inside {nvsc_pkg::ST_HW_PULSE, nvsc_pkg::ST_HW_WAIT, nvsc_pkg::ST_RECOVER}
      |-> pins_o.ce_n)
    else $error("access before store pin released");

  hw_pulse_width_a: assert property ( // RL5
    $rose(hsb_oe_o) |-> hsb_oe_o [*8] ##17 hsb_oe_o ##1 !hsb_oe_o)
    else $error("store pin pulse has wrong width");

endmodule

/* File: verification/nvsc_mem_model.sv */
// Behavioural model of the nonvolatile SRAM driven by the host sequencer
`timescale 1ns/1ps
module nvsc_mem_model #(
  parameter int unsigned ST_CYC = 40,
  parameter int unsigned RC_CYC = 15
) (
  input  wire logic                   clk_i,      // Sample clock
  input  nvsc_pkg::nvsc_pins_t        pins_i,     // Host pins
  input  wire logic                   hsb_i,      // Store/busy wire level
  output logic [nvsc_pkg::DATA_W-1:0] dq_o,       // Data driven to host
  output logic                        hsb_pull_o, // Pulls store/busy low
  output int                          stores_o,   // Completed stores
  output int                          recalls_o,  // Completed recalls
  output int                          faults_o    // Host misuse seen
);
  logic [7:0]  sram [0:8191];
  logic [7:0]  shadow [0:8191];
  logic [12:0] seq [0:4] = '{13'h0000, 13'h1555, 13'h0aaa, 13'h1fff, 13'h10f0};
  logic [7:0]  last = 8'h00;
  logic [2:0]  step = 3'h0;
  int          busy = 0;
  logic        kind_store = 1'b0;
  logic        ce_q = 1'b1;
  logic        we_first = 1'b0;
  logic        dirty = 1'b0;
  logic        inhibit = 1'b0;
  logic        reading;
  logic        fall;

  initial
  begin
    for (int i = 0; i < 8192; i++)
    begin
      sram[i] = 8'h00;
      shadow[i] = 8'h00;
    end
    hsb_pull_o = 1'b0;
    stores_o = 0;
    recalls_o = 0;
    faults_o = 0;
  end

  assign fall = ce_q && !pins_i.ce_n;
  // Output enable gates the drive only, never a launch
  assign reading = !pins_i.ce_n && !pins_i.oe_n && pins_i.we_n && hsb_i && busy == 0
                   && !inhibit && !we_first;
  // Undriven bus shows the inverse of its last value
  assign dq_o = reading ? sram[pins_i.addr] : ~last;

  always @(posedge clk_i)
  begin
    last <= dq_o;
    ce_q <= pins_i.ce_n;
    if (busy != 0)
    begin
      // Cycle runs out whatever the pins do
      busy <= busy - 1;
      if (fall)
        faults_o <= faults_o + 1;
      if (busy == 1)
      begin
        hsb_pull_o <= 1'b0;
        for (int i = 0; i < 8192; i++)
          if (kind_store)
            shadow[i] <= sram[i];
          else
            sram[i] <= shadow[i];
        if (kind_store)
          stores_o <= stores_o + 1;
        else
          recalls_o <= recalls_o + 1;
      end
    end
    else if (!hsb_i && !inhibit)
    begin
      inhibit <= 1'b1;
      step <= 3'h0;
      if (dirty)
      begin
        busy <= ST_CYC;
        kind_store <= 1'b1;
        hsb_pull_o <= 1'b1;
        dirty <= 1'b0;
      end
    end
    else if (inhibit)
    begin
      if (fall)
        faults_o <= faults_o + 1;
      if (hsb_i)
        inhibit <= 1'b0;
    end
    else
    begin
      if (fall)
      begin
        we_first <= !pins_i.we_n;
        if (!pins_i.we_n)
          step <= 3'h0;
        else if (step == 3'h5 && (pins_i.addr == 13'h0f0f || pins_i.addr == 13'h0f0e))
        begin
          busy <= pins_i.addr[0] ? ST_CYC : RC_CYC;
          kind_store <= pins_i.addr[0];
          step <= 3'h0;
          if (pins_i.addr[0])
            dirty <= 1'b0;
        end
        else if (step < 3'h5 && pins_i.addr == seq[step])
          step <= step + 3'h1;
        else
          step <= (pins_i.addr == 13'h0000) ? 3'h1 : 3'h0;
      end
      if (!pins_i.ce_n && !pins_i.we_n)
      begin
        sram[pins_i.addr] <= pins_i.dq;
        dirty <= 1'b1;
        if (!fall && !we_first)
          faults_o <= faults_o + 1;
      end
    end
  end
endmodule

/* File: verification/nvsc_host_tb.sv */
// Self-checking bench of the nonvolatile SRAM host sequencer
`timescale 1ns/1ps
module nvsc_host_tb;
  localparam int unsigned STORE_N  = 50;
  localparam int unsigned RECALL_N = 20;

  logic                 sys_clk_i = 1'b0;
  logic                 reset_i = 1'b1;
  logic                 cmd_valid_i = 1'b0;
  nvsc_pkg::nvsc_cmd_t  cmd_i = '0;
  logic                 cmd_ready_o;
  logic                 rsp_valid_o;
  logic                 busy_o;
  logic                 hsb_o;
  logic                 hsb_oe_o;
  logic                 mdl_pull;
  logic                 hsb_wire;
  logic [7:0]           rsp_data_o;
  logic [7:0]           mdl_dq;
  logic [7:0]           dq_bus;
  nvsc_pkg::nvsc_pins_t pins_o;
  int                   stores;
  int                   recalls;
  int                   faults;
  int                   bad_count = 0;
  int                   checks_done = 0;

  assign dq_bus = pins_o.dq_oe ? pins_o.dq : mdl_dq;
  // Open-drain wire with pull-up
  assign hsb_wire = ((hsb_oe_o && !hsb_o) || mdl_pull) ? 1'b0 : 1'b1;

  nvsc_host #(.STORE_CYC(STORE_N), .RECALL_CYC(RECALL_N)) DUT (
    .sys_clk_i(sys_clk_i), .reset_i(reset_i), .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i),
    .cmd_ready_o(cmd_ready_o), .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o),
    .busy_o(busy_o), .dq_i(dq_bus), .pins_o(pins_o), .hsb_i(hsb_wire), .hsb_o(hsb_o),
    .hsb_oe_o(hsb_oe_o));

  nvsc_mem_model mem (
    .clk_i(sys_clk_i), .pins_i(pins_o), .hsb_i(hsb_wire), .dq_o(mdl_dq),
    .hsb_pull_o(mdl_pull), .stores_o(stores), .recalls_o(recalls), .faults_o(faults));

  initial
  begin
    forever #5 sys_clk_i = ~sys_clk_i;
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick();
    @(posedge sys_clk_i);
    #1;
  endtask

  task automatic wait_ready(input int limit);
    int n;
    n = 0;
    while (cmd_ready_o !== 1'b1 && n < limit)
    begin
      tick();
      n++;
    end
    check(cmd_ready_o, 1'b1);
  endtask

  task automatic issue(input nvsc_pkg::nvsc_op_t op, input logic [12:0] a, input logic [7:0] d);
    wait_ready(100);
    cmd_i = '{op: op, addr: a, data: d};
    cmd_valid_i = 1'b1;
    tick();
    cmd_valid_i = 1'b0;
  endtask

  task automatic read_chk(input logic [12:0] a, input logic [7:0] exp);
    int n;
    n = 0;
    issue(nvsc_pkg::OP_READ, a, 8'h00);
    while (rsp_valid_o !== 1'b1 && n < 30)
    begin
      tick();
      n++;
    end
    check(rsp_valid_o, 1'b1);
    check(rsp_data_o, exp);
  endtask

  task automatic t_rw();
    logic [12:0] a [4] = '{13'h0000, 13'h1fff, 13'h0aaa, 13'h1555};
    logic [7:0]  d [4] = '{8'ha5, 8'h5a, 8'h3c, 8'hc3};
    for (int i = 0; i < 4; i++)
      issue(nvsc_pkg::OP_WRITE, a[i], d[i]);
    for (int i = 0; i < 4; i++)
      read_chk(a[i], d[i]);
  endtask

  task automatic t_store_recall();
    int s0;
    int r0;
    s0 = stores;
    r0 = recalls;
    issue(nvsc_pkg::OP_WRITE, 13'h0123, 8'h6e);
    issue(nvsc_pkg::OP_STORE, 13'h0000, 8'h00);
    check(busy_o, 1'b1);
    wait_ready(STORE_N + 200);
    check(stores, s0 + 1);
    issue(nvsc_pkg::OP_WRITE, 13'h0123, 8'h11);
    read_chk(13'h0123, 8'h11);
    issue(nvsc_pkg::OP_RECALL, 13'h0000, 8'h00);
    wait_ready(RECALL_N + 200);
    check(recalls, r0 + 1);
    read_chk(13'h0123, 8'h6e);
    check(faults, 0);
  endtask

  task automatic t_hw();
    int s0;
    int n;
    issue(nvsc_pkg::OP_WRITE, 13'h1fff, 8'h77);
    s0 = stores;
    issue(nvsc_pkg::OP_HW_STORE, 13'h0000, 8'h00);
    n = 0;
    while (hsb_oe_o !== 1'b1 && n < 5)
    begin
      tick();
      n++;
    end
    check(hsb_o, 1'b0);
    n = 0;
    while (hsb_oe_o === 1'b1 && n < 100)
    begin
      tick();
      n++;
    end
    check(n, nvsc_pkg::ASSERT_CYC);
    wait_ready(300);
    check(stores, s0 + 1);
    issue(nvsc_pkg::OP_HW_STORE, 13'h0000, 8'h00);
    wait_ready(300);
    check(stores, s0 + 1);
    read_chk(13'h1fff, 8'h77);
    check(faults, 0);
  endtask

  task automatic t_reset();
    int s0;
    issue(nvsc_pkg::OP_STORE, 13'h0000, 8'h00);
    repeat (20) tick();
    reset_i = 1'b1;
    tick();
    tick();
    check({pins_o.ce_n, hsb_oe_o, busy_o, cmd_ready_o}, 4'h8);
    reset_i = 1'b0;
    s0 = stores;
    wait_ready(10);
    read_chk(13'h1fff, 8'h77);
    issue(nvsc_pkg::OP_STORE, 13'h0000, 8'h00);
    wait_ready(STORE_N + 200);
    check(stores, s0 + 1);
    check(faults, 0);
  endtask

  initial
  begin
    #200000;
    bad_count++;
    report_and_stop();
  end

  initial
  begin
    repeat (2) @(posedge sys_clk_i);
    #1;
    reset_i = 1'b0;
    t_rw();
    t_store_recall();
    t_hw();
    t_reset();
    report_and_stop();
  end
endmodule
